//--- src/converter_status_config_regs.sv
// Summary of operation
// - upper status bit 7 is 1 while any output voltage flag is set.
// - upper status bit 6 is 1 while any output current flag is set.
// - upper status bit 5 is 1 after a bias supply voltage fault.
// - upper status bit 3 reads 1 while power is not good.
// - voltage flag bit 7 records an output overvoltage fault.
// - voltage flag bit 6 records an output overvoltage warning.
// - voltage flag bit 5 records an output undervoltage warning.
// - voltage flag bit 4 records undervoltage fault; bits 3 to 0 zero.
// - current flag bit 7 records a positive overcurrent fault.
// - current flag bit 6 records overcurrent with undervoltage together.
// - current flag bit 4 records negative overcurrent; others read zero.
// - bad_command_flag flag bit 7 sets on an invalid or unsupported command code.
// - bad_command_flag flag bit 6 sets on invalid or unsupported data.
// - bad_command_flag flag bit 5 sets on a failed packet error check.
// - bad_command_flag flag bit 1 sets only when too many data bytes arrive.
// - an 8-bit scratch pad stores and returns any host value.
// - delay config bits 7 and 6 are read-only zero.
// - delay config bits 5 to 3 select the power-good delay.
// - delay config bits 2 to 0 select power-on delay, reset 010b.
// - power-good delay 256 us doubling to 16.384 ms; code 7 131.072 ms.
// - power-on delay 256 us doubling per code up to 32.768 ms.
`include "conv_regs_map.svh"
`timescale 1ns/1ps
`default_nettype none
module converter_status_config_regs #(
  parameter int unsigned BASE_CYCLES = `DLY_BASE_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // command port from the bus transaction engine
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire conv_regs_pkg::reg_byte_t cmdCode,
  input wire conv_regs_pkg::reg_byte_t cmdData,
  input wire logic cmdForeign,
  output logic rdValid,
  output conv_regs_pkg::reg_byte_t rdData,
  // protocol error events from the transaction engine
  input wire logic pecFailEvent,
  input wire logic extraByteEvent,
  // analog fault and warning events
  input wire logic overVoltageFaultEvent,
  input wire logic overVoltageWarningEvent,
  input wire logic underVoltageWarningEvent,
  input wire logic underVoltageFaultEvent,
  input wire logic positiveCurrentFaultEvent,
  input wire logic negativeCurrentFaultEvent,
  input wire logic biasFaultEvent,
  // power sequencing
  input wire logic enableRequest,
  input wire logic outputInRegulation,
  output logic powerOnDone,
  output logic powerGoodNotFlag
);
  import conv_regs_pkg::*;

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------

  logic isRead;
  logic isWrite;
  logic ownCode;
  logic statusCode;
  logic clearCmd;
  logic badCommand;
  logic badData;

  // status codes never accept data; writing them counts as bad data
  assign isRead = cmdValid && !cmdWrite;
  assign isWrite = cmdValid && cmdWrite;
  always_comb begin
    statusCode = 1'b0;
    ownCode = 1'b1;
    if (cmdCode == `CMD_STATUS_UPPER || cmdCode == `CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS ||
        cmdCode == `CMD_OUTPUT_CURRENT_SUMMARY_FLAGS || cmdCode == `CMD_BAD_COMMAND_FLAG_FLAGS) begin
      statusCode = 1'b1;
    end else if (cmdCode != `CMD_SCRATCH_PAD &&
                 cmdCode != `CMD_DELAY_CONFIG &&
                 cmdCode != `CMD_CLEAR_FAULTS) begin
      ownCode = 1'b0;
    end
  end

  assign clearCmd = cmdValid && (cmdCode == `CMD_CLEAR_FAULTS);
  assign badCommand = cmdValid && !ownCode && !cmdForeign;
  // bad data: a write to a status code, or nonzero reserved delay bits
  assign badData = isWrite && (statusCode || ((cmdCode == `CMD_DELAY_CONFIG)
    && (cmdData[`DLY_RSVD_MSB:`DLY_RSVD_LSB] != 2'b00)));

  // ---------------------------------------------------------------
  // sticky fault flags
  // ---------------------------------------------------------------

  logic ovFault_q;
  logic ovWarn_q;
  logic uvWarn_q;
  logic uvFault_q;
  logic posCurFault_q;
  logic combFault_q;
  logic negCurFault_q;
  logic biasFault_q;
  logic cmdFlag_q;
  logic dataFlag_q;
  logic pecFlag_q;
  logic otherFlag_q;

  // a set that lands with the clear command wins, so no event is lost
  function automatic logic stick(input logic cur, input logic ev,
                                 input logic clr);
    stick = ev || (cur && !clr);
  endfunction

  // output voltage flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ovFault_q <= 1'b0;
      ovWarn_q <= 1'b0;
      uvWarn_q <= 1'b0;
      uvFault_q <= 1'b0;
    end else begin
      ovFault_q <= stick(ovFault_q, overVoltageFaultEvent, clearCmd);
      ovWarn_q <= stick(ovWarn_q, overVoltageWarningEvent, clearCmd);
      uvWarn_q <= stick(uvWarn_q, underVoltageWarningEvent, clearCmd);
      uvFault_q <= stick(uvFault_q, underVoltageFaultEvent, clearCmd);
    end
  end

  // output current and bias supply flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      posCurFault_q <= 1'b0;
      combFault_q <= 1'b0;
      negCurFault_q <= 1'b0;
      biasFault_q <= 1'b0;
    end else begin
      posCurFault_q <= stick(posCurFault_q, positiveCurrentFaultEvent,
                             clearCmd);
      combFault_q <= stick(combFault_q,
                           positiveCurrentFaultEvent && underVoltageFaultEvent,
                           clearCmd);
      negCurFault_q <= stick(negCurFault_q, negativeCurrentFaultEvent,
                             clearCmd);
      biasFault_q <= stick(biasFault_q, biasFaultEvent, clearCmd);
    end
  end

  // communication flags
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cmdFlag_q <= 1'b0;
      dataFlag_q <= 1'b0;
      pecFlag_q <= 1'b0;
      otherFlag_q <= 1'b0;
    end else begin
      cmdFlag_q <= stick(cmdFlag_q, badCommand, clearCmd);
      dataFlag_q <= stick(dataFlag_q, badData, clearCmd);
      pecFlag_q <= stick(pecFlag_q, pecFailEvent, clearCmd);
      otherFlag_q <= stick(otherFlag_q, extraByteEvent, clearCmd);
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------

  reg_byte_t scratch_q;
  delay_code_t pgdSel_q;
  delay_code_t podSel_q;

  // scratch pad has no effect on the converter
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scratch_q <= `SCRATCH_RESET;
    end else if (isWrite && cmdCode == `CMD_SCRATCH_PAD) begin
      scratch_q <= cmdData;
    end
  end

  // a write with bad reserved bits is refused whole
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pgdSel_q <= `PGD_RESET;
      podSel_q <= `POD_RESET;
    end else if (isWrite && cmdCode == `CMD_DELAY_CONFIG && !badData) begin
      pgdSel_q <= cmdData[`DLY_PGD_MSB:`DLY_PGD_LSB];
      podSel_q <= cmdData[`DLY_POD_MSB:`DLY_POD_LSB];
    end
  end

  // ---------------------------------------------------------------
  // register images
  // ---------------------------------------------------------------

  reg_byte_t voutImg;
  reg_byte_t ioutImg;
  reg_byte_t commImg;
  reg_byte_t upperImg;
  reg_byte_t delayImg;

  // unused positions are tied to zero
  always_comb begin
    voutImg = 8'h00;
    voutImg[`OUTPUT_VOLTAGE_SUMMARY_OVF_BIT] = ovFault_q;
    voutImg[`OUTPUT_VOLTAGE_SUMMARY_OVW_BIT] = ovWarn_q;
    voutImg[`OUTPUT_VOLTAGE_SUMMARY_UVW_BIT] = uvWarn_q;
    voutImg[`OUTPUT_VOLTAGE_SUMMARY_UVF_BIT] = uvFault_q;
    ioutImg = 8'h00;
    ioutImg[`OUTPUT_CURRENT_SUMMARY_OCF_BIT] = posCurFault_q;
    ioutImg[`OUTPUT_CURRENT_SUMMARY_COMBINED_CURRENT_VOLTAGE_FAULT_BIT] = combFault_q;
    ioutImg[`OUTPUT_CURRENT_SUMMARY_UCF_BIT] = negCurFault_q;
    commImg = 8'h00;
    commImg[`BAD_COMMAND_FLAG_CMD_BIT] = cmdFlag_q;
    commImg[`BAD_COMMAND_FLAG_DATA_BIT] = dataFlag_q;
    commImg[`BAD_COMMAND_FLAG_PEC_BIT] = pecFlag_q;
    commImg[`BAD_COMMAND_FLAG_OTHER_BIT] = otherFlag_q;
    upperImg = 8'h00;
    upperImg[`UPPER_OUTPUT_VOLTAGE_SUMMARY_BIT] = |voutImg;
    upperImg[`UPPER_OUTPUT_CURRENT_SUMMARY_BIT] = |ioutImg;
    upperImg[`UPPER_BIAS_BIT] = biasFault_q;
    upperImg[`UPPER_POWER_GOOD_NOT_FLAG_N_BIT] = powerGoodNotFlag;
    delayImg = {2'b00, pgdSel_q, podSel_q};
  end

  // ---------------------------------------------------------------
  // read return
  // ---------------------------------------------------------------

  // answer one cycle after the request; unknown codes return zero
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rdValid <= 1'b0;
      rdData <= 8'h00;
    end else begin
      rdValid <= isRead;
      if (!isRead) begin
        rdData <= rdData;
      end else if (cmdCode == `CMD_STATUS_UPPER) begin
        rdData <= upperImg;
      end else if (cmdCode == `CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS) begin
        rdData <= voutImg;
      end else if (cmdCode == `CMD_OUTPUT_CURRENT_SUMMARY_FLAGS) begin
        rdData <= ioutImg;
      end else if (cmdCode == `CMD_BAD_COMMAND_FLAG_FLAGS) begin
        rdData <= commImg;
      end else if (cmdCode == `CMD_SCRATCH_PAD) begin
        rdData <= scratch_q;
      end else if (cmdCode == `CMD_DELAY_CONFIG) begin
        rdData <= delayImg;
      end else begin
        rdData <= 8'h00;
      end
    end
  end

  // ---------------------------------------------------------------
  // power-on and power-good delays
  // ---------------------------------------------------------------

  // base step doubled per code; the long power-good code is special
  function automatic delay_count_t delayCycles(input delay_code_t code,
                                               input logic isGood);
    delay_count_t base;
    base = delay_count_t'(BASE_CYCLES);
    if (isGood && code == 3'h7) begin
      delayCycles = base << `PGD_LONG_SHIFT;
    end else begin
      delayCycles = base << code;
    end
  endfunction

  seq_state_e state_q;
  delay_count_t count_q;

  // selection sampled as each wait starts; a mid-wait write acts next time
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= SEQ_OFF;
      count_q <= 32'h0000_0000;
    end else if (!enableRequest) begin
      state_q <= SEQ_OFF;
      count_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        SEQ_OFF: begin
          state_q <= SEQ_POWER_ON_WAIT;
          count_q <= delayCycles(podSel_q, 1'b0) - 32'h0000_0001;
        end
        SEQ_POWER_ON_WAIT: begin
          if (count_q == 32'h0000_0000) begin
            state_q <= SEQ_GOOD_WAIT;
            count_q <= delayCycles(pgdSel_q, 1'b1) - 32'h0000_0001;
          end else begin
            count_q <= count_q - 32'h0000_0001;
          end
        end
        SEQ_GOOD_WAIT: begin
          if (!outputInRegulation) begin
            count_q <= delayCycles(pgdSel_q, 1'b1) - 32'h0000_0001;
          end else if (count_q == 32'h0000_0000) begin
            state_q <= SEQ_GOOD;
          end else begin
            count_q <= count_q - 32'h0000_0001;
          end
        end
        SEQ_GOOD: begin
          if (!outputInRegulation) begin
            state_q <= SEQ_GOOD_WAIT;
            count_q <= delayCycles(pgdSel_q, 1'b1) - 32'h0000_0001;
          end
        end
        default: begin
          state_q <= SEQ_OFF;
        end
      endcase
    end
  end

  // outputs from flip-flops so the pin never glitches
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      powerOnDone <= 1'b0;
      powerGoodNotFlag <= 1'b1;
    end else begin
      powerOnDone <= enableRequest &&
        (state_q == SEQ_GOOD_WAIT || state_q == SEQ_GOOD);
      powerGoodNotFlag <= !(enableRequest && state_q == SEQ_GOOD &&
                            outputInRegulation);
    end
  end

endmodule

`default_nettype wire

//--- src/conv_regs_map.svh
`ifndef CONV_REGS_MAP_SVH
`define CONV_REGS_MAP_SVH

// command codes of the registers held in this bank
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_STATUS_UPPER 8'h79
`define CMD_OUTPUT_VOLTAGE_SUMMARY_FLAGS 8'h7a
`define CMD_OUTPUT_CURRENT_SUMMARY_FLAGS 8'h7b
`define CMD_BAD_COMMAND_FLAG_FLAGS 8'h7e
`define CMD_SCRATCH_PAD 8'hd0
`define CMD_DELAY_CONFIG 8'hd1

// upper status summary byte fields
`define UPPER_OUTPUT_VOLTAGE_SUMMARY_BIT 7
`define UPPER_OUTPUT_CURRENT_SUMMARY_BIT 6
`define UPPER_BIAS_BIT 5
`define UPPER_POWER_GOOD_NOT_FLAG_N_BIT 3

// output voltage flag fields
`define OUTPUT_VOLTAGE_SUMMARY_OVF_BIT 7
`define OUTPUT_VOLTAGE_SUMMARY_OVW_BIT 6
`define OUTPUT_VOLTAGE_SUMMARY_UVW_BIT 5
`define OUTPUT_VOLTAGE_SUMMARY_UVF_BIT 4

// output current flag fields
`define OUTPUT_CURRENT_SUMMARY_OCF_BIT 7
`define OUTPUT_CURRENT_SUMMARY_COMBINED_CURRENT_VOLTAGE_FAULT_BIT 6
`define OUTPUT_CURRENT_SUMMARY_UCF_BIT 4

// communication flag fields
`define BAD_COMMAND_FLAG_CMD_BIT 7
`define BAD_COMMAND_FLAG_DATA_BIT 6
`define BAD_COMMAND_FLAG_PEC_BIT 5
`define BAD_COMMAND_FLAG_OTHER_BIT 1

// delay configuration fields
`define DLY_RSVD_MSB 7
`define DLY_RSVD_LSB 6
`define DLY_PGD_MSB 5
`define DLY_PGD_LSB 3
`define DLY_POD_MSB 2
`define DLY_POD_LSB 0

// reset values
`define SCRATCH_RESET 8'h00
`define PGD_RESET 3'h0
`define POD_RESET 3'h2

// timing: base delay step and the clock period, both in ns
`define DLY_BASE_NS 256000
`define CLK_PERIOD_NS 10
`define DLY_BASE_CYCLES ((`DLY_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// the top power-good code jumps to 512 base steps instead of 128
`define PGD_LONG_SHIFT 9

`endif

//--- src/conv_regs_pkg.sv
package conv_regs_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [2:0] delay_code_t;
  typedef logic [31:0] delay_count_t;

  // power-up sequencing states
  typedef enum logic [1:0] {
    SEQ_OFF,
    SEQ_POWER_ON_WAIT,
    SEQ_GOOD_WAIT,
    SEQ_GOOD
  } seq_state_e;

endpackage

//--- bench/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // clock
  input wire logic clock,
  // command side
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] cmdCode,
  output logic [7:0] cmdData,
  // answer side
  input wire logic rdValid,
  input wire logic [7:0] rdData
);
  // ----
  // host commands
  // ----
  // strobe is idle at time zero so nothing is taken during reset
  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdData = 8'h00;
  end

  // one single-byte command, held across exactly one rising edge;
  // data is inverted afterwards so a stale byte never looks valid
  task automatic issue(input logic w, input logic [7:0] c,
                       input logic [7:0] d, output logic [7:0] r);
    @(negedge clock);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdCode = c;
    cmdData = d;
    @(negedge clock);
    r = (rdValid === 1'b1) ? rdData : 8'hxx;
    cmdValid = 1'b0;
    cmdData = ~d;
  endtask

  task automatic wr(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    issue(1'b1, c, d, r);
  endtask

  task automatic rd(input logic [7:0] c, output logic [7:0] d);
    issue(1'b0, c, 8'h00, d);
  endtask
endmodule
`default_nettype wire

//--- bench/conv_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module conv_regs_checker #(
  parameter int unsigned BASE_CYCLES = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // command port
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire conv_regs_pkg::reg_byte_t cmdCode,
  input wire conv_regs_pkg::reg_byte_t cmdData,
  input wire logic cmdForeign,
  input wire logic rdValid,
  input wire conv_regs_pkg::reg_byte_t rdData,
  // events and sequencing
  input wire logic overVoltageFaultEvent,
  input wire logic enableRequest,
  input wire logic powerOnDone,
  input wire logic powerGoodNotFlag
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  logic rdCmd;
  // a read request taken at this edge
  assign rdCmd = cmdValid && !cmdWrite;

  a_read_answer: assert property (rdCmd |=> rdValid)
    else $error("read got no answer");
  a_no_stray: assert property (!rdCmd |=> !rdValid)
    else $error("answer without read");
  a_scratch_back: assert property (
    (cmdValid && cmdWrite && cmdCode == 8'hd0) ##1 !cmdValid
    ##1 (rdCmd && cmdCode == 8'hd0) |=> rdData == $past(cmdData, 3))
    else $error("scratch readback wrong");
  a_output_voltage_summary_low_zero: assert property (
    rdValid && $past(cmdCode) == 8'h7a |-> rdData[3:0] == 4'h0)
    else $error("voltage flags low bits set");
  a_output_current_summary_unused_zero: assert property (
    rdValid && $past(cmdCode) == 8'h7b |-> !rdData[5] && !rdData[3:0])
    else $error("current flags unused bits set");
  a_delay_top_zero: assert property (
    rdValid && $past(cmdCode) == 8'hd1 |-> rdData[7:6] == 2'b00)
    else $error("delay config top bits set");
  a_upper_power_good_not_flag: assert property (
    rdValid && $past(cmdCode) == 8'h79
    |-> rdData[3] == $past(powerGoodNotFlag))
    else $error("upper byte power good bit wrong");
  a_ovf_latched: assert property (
    overVoltageFaultEvent ##1 !cmdValid ##1 (rdCmd && cmdCode == 8'h7a)
    |=> rdData[7])
    else $error("overvoltage fault not recorded");
  a_bad_code_flag: assert property (
    (cmdValid && !cmdForeign && cmdCode == 8'h55) ##1 !cmdValid
    ##1 (rdCmd && cmdCode == 8'h7e) |=> rdData[7])
    else $error("bad command not flagged");
  a_enable_drop: assert property (
    $fell(enableRequest) |-> ##[1:2] (powerGoodNotFlag && !powerOnDone))
    else $error("outputs stay up after disable");
  a_good_needs_on: assert property (
    !powerGoodNotFlag |-> powerOnDone)
    else $error("power good before power on");

  int unsigned onCount;
  // cycles since power-on done rose, saturating at one base step
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      onCount <= '0;
    end else if (!powerOnDone) begin
      onCount <= '0;
    end else if (onCount < BASE_CYCLES) begin
      onCount <= onCount + 32'h0000_0001;
    end
  end

  a_good_min_delay: assert property (
    onCount < BASE_CYCLES |-> powerGoodNotFlag)
    else $error("power good before shortest delay");

  c_upper_read: cover property (rdCmd && cmdCode == 8'h79);
  c_good: cover property ($fell(powerGoodNotFlag));
  c_clear: cover property (cmdValid && cmdCode == 8'h03);
endmodule

bind converter_status_config_regs conv_regs_checker #(
  .BASE_CYCLES(BASE_CYCLES)
) conv_regs_checker_inst (
  .clock(clock), .rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
  .cmdCode(cmdCode), .cmdData(cmdData), .cmdForeign(cmdForeign),
  .rdValid(rdValid), .rdData(rdData),
  .overVoltageFaultEvent(overVoltageFaultEvent),
  .enableRequest(enableRequest), .powerOnDone(powerOnDone),
  .powerGoodNotFlag(powerGoodNotFlag)
);
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import conv_regs_pkg::*;
  logic clock, rst, cmdValid, cmdWrite, cmdForeign, rdValid;
  reg_byte_t cmdCode, cmdData, rdData, got, cfg;
  logic [8:0] evt;
  logic enableRequest, inReg, powerOnDone, pgN;
  int mismatches, totalChecks, n, c, d;

  // ----
  // design and host
  // ----
  converter_status_config_regs #(.BASE_CYCLES(4))
      converter_status_config_regs_inst (
    .clock(clock), .rst(rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdData(cmdData), .cmdForeign(cmdForeign),
    .rdValid(rdValid), .rdData(rdData), .pecFailEvent(evt[7]),
    .extraByteEvent(evt[8]), .overVoltageFaultEvent(evt[0]),
    .overVoltageWarningEvent(evt[1]), .underVoltageWarningEvent(evt[2]),
    .underVoltageFaultEvent(evt[3]), .positiveCurrentFaultEvent(evt[4]),
    .negativeCurrentFaultEvent(evt[5]), .biasFaultEvent(evt[6]),
    .enableRequest(enableRequest), .outputInRegulation(inReg),
    .powerOnDone(powerOnDone), .powerGoodNotFlag(pgN));
  host_model host_model_inst (.clock(clock), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdData(cmdData),
    .rdValid(rdValid), .rdData(rdData));

  // ----
  // helpers
  // ----
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] s);
    totalChecks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic rd(input reg_byte_t a, input reg_byte_t e);
    host_model_inst.rd(a, got);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, got});
  endtask

  // one-cycle event pulse, launched off the sampling edge
  task automatic pulse(input logic [8:0] m);
    @(negedge clock);
    evt = m;
    @(negedge clock);
    evt = '0;
  endtask

  // bounded wait; sel 0 for power-on done, 1 for power good
  task automatic waitUp(input int sel, output int k);
    k = 0;
    while ((sel ? !pgN : powerOnDone) !== 1'b1 && k < 3000) begin
      @(negedge clock);
      k++;
    end
  endtask

  task automatic finishTest;
    $display("checks %0d mismatches %0d", totalChecks, mismatches);
    if (mismatches == 0 && totalChecks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog well beyond the few thousand cycles the tests need
  initial begin
    #200000;
    mismatches++;
    finishTest;
  end

  // ----
  // tests
  // ----
  initial begin
    rst = 1'b1;
    cmdForeign = 1'b0;
    evt = '0;
    enableRequest = 1'b0;
    inReg = 1'b0;
    repeat (2) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    rd(8'hd1, 8'h02);
    rd(8'hd0, 8'h00);
    rd(8'h79, 8'h08);
    rd(8'h7e, 8'h00);
    host_model_inst.wr(8'hd0, 8'h5a);
    rd(8'hd0, 8'h5a);
    host_model_inst.wr(8'hd0, 8'ha5);
    rd(8'hd0, 8'ha5);
    host_model_inst.wr(8'hd1, 8'h3f);
    rd(8'hd1, 8'h3f);
    host_model_inst.wr(8'hd1, 8'hc0);
    rd(8'hd1, 8'h3f);
    rd(8'h7e, 8'h40);
    host_model_inst.wr(8'h03, 8'h00);
    host_model_inst.wr(8'h7a, 8'hff);
    rd(8'h7a, 8'h00);
    rd(8'h7e, 8'h40);
    host_model_inst.wr(8'h03, 8'h00);
    cmdForeign = 1'b1;
    host_model_inst.wr(8'h55, 8'h00);
    cmdForeign = 1'b0;
    rd(8'h7e, 8'h00);
    rd(8'h55, 8'h00);
    rd(8'h7e, 8'h80);
    host_model_inst.wr(8'h03, 8'h00);
    pulse(9'h080);
    pulse(9'h100);
    rd(8'h7e, 8'h22);
    // each voltage event alone, cleared in between
    for (n = 0; n < 4; n++) begin
      host_model_inst.wr(8'h03, 8'h00);
      pulse(9'h001 << n);
      rd(8'h7a, 8'h80 >> n);
      rd(8'h79, 8'h88);
    end
    // a read of the clear code clears the flags as well
    host_model_inst.rd(8'h03, got);
    rd(8'h7a, 8'h00);
    // an event in the clearing cycle must survive the clear
    fork
      host_model_inst.wr(8'h03, 8'h00);
      pulse(9'h001);
    join
    rd(8'h7a, 8'h80);
    host_model_inst.wr(8'h03, 8'h00);
    pulse(9'h010);
    rd(8'h7b, 8'h80);
    rd(8'h79, 8'h48);
    host_model_inst.wr(8'h03, 8'h00);
    pulse(9'h018);
    rd(8'h7b, 8'hc0);
    host_model_inst.wr(8'h03, 8'h00);
    pulse(9'h020);
    rd(8'h7b, 8'h10);
    host_model_inst.wr(8'h03, 8'h00);
    pulse(9'h040);
    rd(8'h79, 8'h28);
    host_model_inst.wr(8'h03, 8'h00);
    // power-up with two delay settings, the long top code among them
    for (n = 0; n < 2; n++) begin
      cfg = n ? 8'h38 : 8'h11;
      host_model_inst.wr(8'hd1, cfg);
      inReg = 1'b1;
      enableRequest = 1'b1;
      d = 4 << cfg[2:0];
      waitUp(0, c);
      chk("on delay", 1, c >= d && c <= d + 3);
      d = (cfg[5:3] == 3'h7) ? (4 << 9) : (4 << cfg[5:3]);
      waitUp(1, c);
      chk("good delay", 1, c >= d - 1 && c <= d + 2);
      rd(8'h79, 8'h00);
      inReg = 1'b0;
      repeat (2) @(negedge clock);
      chk("good lost", 1, pgN);
      enableRequest = 1'b0;
      repeat (3) @(negedge clock);
      chk("on after off", 0, powerOnDone);
    end
    // a second reset in mid-run must bring back every default
    host_model_inst.wr(8'hd0, 8'h77);
    pulse(9'h080);
    rst = 1'b1;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    rd(8'hd1, 8'h02);
    rd(8'hd0, 8'h00);
    rd(8'h7e, 8'h00);
    finishTest;
  end
endmodule
`default_nettype wire
